// file: design/pbs_signal_counters.sv
// Overview of operation
// - Transmit vector at index 03, read/write, cleared by reset, always readable.
// - Writes to transmit vector or count while signaling are dropped and flag host error.
// - Vector sent one bit per interval: Halt for one, Master for zero, 1-16 bits.
// - Sending starts at bit 0 and climbs until the programmed count is sent.
// - Writing the transmit vector sets signaling active; program the count first.
// - Vector count at index 04, read/write, reset clear, bits 15..4 read zero.
// - Count field 3..0 holds bits to send minus one.
// - Receive vector at index 16 captures bit n during transmit bit n; Halt is one.
// - Receive vector readable anytime; may be partial while signaling.
// - Violation counter at index 18, read-only, cleared by read or reset, 8 bits.
// - Violation counter counts decoded violation symbols and wraps past 255.
// - Violation event on every increment or on wrap, per control select bit.
// - Idle gap monitor at index 19, read-only, clear on read or reset, 9 upper zero.
// - Least pair field uses the fixed non-binary code table.
// - Bits 3..0 count minimum occurrences from one, stop at 16; event per select bit.
// - Occurrence field uses the fixed sixteen-entry code table.
// - Link error counter at index 1A, read-only, clear on read or reset, 8 bits.
// - Count equal to limit sets threshold event; counting continues and wraps.
// - Link error limit at index 05, read/write, reset clear, upper bits zero.
// - Event flags bit 15 marks invalid register writes such as writing read-only.
`timescale 1ns/100ps
`default_nettype none
module pbs_signal_counters
  import pbs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Line state towards and from the neighbour
  input wire logic rx_halt_i,
  output logic tx_halt_o,
  output logic tx_master_o,
  output logic signaling_active_o,
  // Symbol decoder and gap reports
  input wire logic violation_symbol_i,
  input wire logic idle_gap_valid_i,
  input wire logic [2:0] idle_gap_pairs_i,
  input wire logic link_error_event_i
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] tx_signal_vector;
    logic [3:0] signal_vector_count;
    logic [15:0] rx_signal_vector;
    logic [7:0] link_error_limit;
    logic violation_event_select;
    logic idle_gap_event_select;
    logic sig_active;
    logic [3:0] bit_idx;
    logic [15:0] bit_cyc;
    logic tx_halt;
    logic tx_master;
    logic [7:0] viol_count;
    logic [2:0] min_pairs;
    logic [4:0] occ;
    logic [7:0] link_count;
    logic host_access_error;
    logic link_error_threshold_event;
    logic idle_gap_event;
    logic violation_count_event;
  } pbs_state_type;

  localparam logic [15:0] BIT_LAST = 16'(SIG_BIT_CYCLES - 1);

  pbs_state_type q;
  pbs_state_type d;

  logic launch;
  logic acc;
  logic [5:0] idx;
  logic mapped;
  logic read_only;
  logic bit_end;
  logic [15:0] evt_word;

  assign idx = paddr_i[7:2];
  // Read side effects happen on the edge that raises pready; the master holds the request
  assign launch = psel_i & penable_i & ~q.pready;
  assign acc = psel_i & penable_i & q.pready;
  assign bit_end = q.sig_active & (q.bit_cyc == BIT_LAST);

  always_comb begin
    case (idx)
      IDX_CONTROL_A, IDX_TX_VECTOR, IDX_VECTOR_COUNT, IDX_LINK_LIMIT: begin
        mapped = 1'b1;
        read_only = 1'b0;
      end
      IDX_RX_VECTOR, IDX_EVENT_FLAGS, IDX_VIOL_COUNT, IDX_IDLE_MONITOR, IDX_LINK_COUNT: begin
        mapped = 1'b1;
        read_only = 1'b1;
      end
      default: begin
        mapped = 1'b0;
        read_only = 1'b0;
      end
    endcase
  end

  always_comb begin
    evt_word = 16'h0000;
    evt_word[EVT_HOST_ERR_BIT] = q.host_access_error;
    evt_word[EVT_LINK_LIMIT_BIT] = q.link_error_threshold_event;
    evt_word[EVT_IDLE_GAP_BIT] = q.idle_gap_event;
    evt_word[EVT_VIOL_BIT] = q.violation_count_event;
  end

  always_comb begin
    logic rd_clr;
    logic [4:0] occ_next;
    logic [7:0] link_next;
    rd_clr = 1'b0;
    occ_next = 5'h00;
    link_next = 8'h00;
    d = q;
    d.pready = launch;
    d.pslverr = launch & (~mapped | (pwrite_i & read_only));
    d.prdata = 32'h0000_0000;

    // Register read: data captured and read-clear applied at the launch edge
    if (launch && !pwrite_i) begin
      rd_clr = 1'b1;
      case (idx)
        IDX_CONTROL_A: begin
          d.prdata[CTLA_VIOL_SEL_BIT] = q.violation_event_select;
          d.prdata[CTLA_IDLE_SEL_BIT] = q.idle_gap_event_select;
          d.prdata[CTLA_SIG_ACTIVE_BIT] = q.sig_active;
        end
        IDX_TX_VECTOR: d.prdata[15:0] = q.tx_signal_vector;
        IDX_VECTOR_COUNT: d.prdata[3:0] = q.signal_vector_count;
        IDX_LINK_LIMIT: d.prdata[7:0] = q.link_error_limit;
        IDX_RX_VECTOR: d.prdata[15:0] = q.rx_signal_vector;
        IDX_EVENT_FLAGS: d.prdata[15:0] = evt_word;
        IDX_VIOL_COUNT: d.prdata[7:0] = q.viol_count;
        IDX_IDLE_MONITOR: d.prdata[6:0] = {min_pairs_code(q.min_pairs), occ_code(q.occ)};
        IDX_LINK_COUNT: d.prdata[7:0] = q.link_count;
        default: d.prdata = 32'h0000_0000;
      endcase
    end
    if (rd_clr) begin
      case (idx)
        IDX_EVENT_FLAGS: begin
          d.host_access_error = 1'b0;
          d.link_error_threshold_event = 1'b0;
          d.idle_gap_event = 1'b0;
          d.violation_count_event = 1'b0;
        end
        IDX_VIOL_COUNT: d.viol_count = 8'h00;
        IDX_IDLE_MONITOR: begin
          d.min_pairs = MIN_PAIRS_RESET;
          d.occ = OCC_RESET;
        end
        IDX_LINK_COUNT: d.link_count = 8'h00;
        default: d.viol_count = d.viol_count;
      endcase
    end

    // Signaling engine
    if (q.sig_active) begin
      d.bit_cyc = q.bit_cyc + 16'h0001;
      if (bit_end) begin
        d.rx_signal_vector[q.bit_idx] = rx_halt_i;
        d.bit_cyc = 16'h0000;
        if (q.bit_idx == q.signal_vector_count) begin
          d.sig_active = 1'b0;
        end else begin
          d.bit_idx = q.bit_idx + 4'h1;
        end
      end
    end

    // Register write at the completing edge
    if (acc && pwrite_i) begin
      case (idx)
        IDX_CONTROL_A: begin
          d.violation_event_select = pwdata_i[CTLA_VIOL_SEL_BIT];
          d.idle_gap_event_select = pwdata_i[CTLA_IDLE_SEL_BIT];
        end
        IDX_TX_VECTOR: begin
          if (q.sig_active) begin
            d.host_access_error = 1'b1;
          end else begin
            d.tx_signal_vector = pwdata_i[15:0];
            d.rx_signal_vector = 16'h0000;
            d.sig_active = 1'b1;
            d.bit_idx = 4'h0;
            d.bit_cyc = 16'h0000;
          end
        end
        IDX_VECTOR_COUNT: begin
          if (q.sig_active) begin
            d.host_access_error = 1'b1;
          end else begin
            d.signal_vector_count = pwdata_i[3:0];
          end
        end
        IDX_LINK_LIMIT: d.link_error_limit = pwdata_i[7:0];
        default: d.host_access_error = 1'b1;
      endcase
    end

    // Violation symbols; a count arriving with a read-clear is kept
    if (violation_symbol_i) begin
      d.viol_count = (rd_clr && idx == IDX_VIOL_COUNT) ? 8'h01 : q.viol_count + 8'h01;
      if (!q.violation_event_select || (q.viol_count == COUNT8_MAX && !(rd_clr && idx == IDX_VIOL_COUNT))) begin
        d.violation_count_event = 1'b1;
      end
    end

    // Idle gap monitor
    if (idle_gap_valid_i) begin
      if (idle_gap_pairs_i < d.min_pairs) begin
        d.min_pairs = idle_gap_pairs_i;
        d.occ = OCC_RESET;
        d.idle_gap_event = 1'b1;
      end else if (idle_gap_pairs_i == d.min_pairs && d.occ != OCC_MAX) begin
        occ_next = d.occ + 5'h01;
        d.occ = occ_next;
        if (!q.idle_gap_event_select || occ_next == OCC_MAX) begin
          d.idle_gap_event = 1'b1;
        end
      end
    end

    // Link error events
    if (link_error_event_i) begin
      link_next = d.link_count + 8'h01;
      d.link_count = link_next;
      if (link_next == q.link_error_limit) begin
        d.link_error_threshold_event = 1'b1;
      end
    end

    // Line state drive follows the bit being sent
    d.tx_halt = d.sig_active & d.tx_signal_vector[d.bit_idx];
    d.tx_master = d.sig_active & ~d.tx_signal_vector[d.bit_idx];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.min_pairs <= MIN_PAIRS_RESET;
      q.occ <= OCC_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign tx_halt_o = q.tx_halt;
  assign tx_master_o = q.tx_master;
  assign signaling_active_o = q.sig_active;

  // Checks
  sequence s_tx_write_idle;
    acc && pwrite_i && idx == IDX_TX_VECTOR && !q.sig_active;
  endsequence

  sequence s_last_bit;
    bit_end && q.bit_idx == q.signal_vector_count;
  endsequence

  a_busy_write_drop: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    acc && pwrite_i && q.sig_active && (idx == IDX_TX_VECTOR || idx == IDX_VECTOR_COUNT)
    |=> $stable(q.tx_signal_vector) && $stable(q.signal_vector_count) && q.host_access_error)
    else $error("write during signaling changed a vector register");

  a_start_signal: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_tx_write_idle |=> q.sig_active && q.bit_idx == 4'h0 && q.tx_signal_vector == $past(pwdata_i[15:0]))
    else $error("transmit vector write did not start signaling");

  a_line_state: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q.sig_active |-> (tx_halt_o == q.tx_signal_vector[q.bit_idx]) && (tx_master_o != tx_halt_o))
    else $error("line state does not match vector bit");

  a_bit_order: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    bit_end && q.bit_idx != q.signal_vector_count |=> q.bit_idx == $past(q.bit_idx) + 4'h1)
    else $error("vector bit order broken");

  a_rx_capture: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    bit_end |=> q.rx_signal_vector[$past(q.bit_idx)] == $past(rx_halt_i))
    else $error("receive bit not captured");

  a_signal_end: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_last_bit |=> !q.sig_active ##1 !tx_halt_o && !tx_master_o)
    else $error("signaling did not end after last bit");

  a_count_upper: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch && !pwrite_i && idx == IDX_VECTOR_COUNT |=> prdata_o[31:4] == 28'h000_0000)
    else $error("vector count upper bits not zero");

  a_viol_wrap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    violation_symbol_i && q.viol_count == COUNT8_MAX && !launch |=> q.viol_count == 8'h00)
    else $error("violation counter did not wrap");

  a_viol_read_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch && !pwrite_i && idx == IDX_VIOL_COUNT && !violation_symbol_i |=> q.viol_count == 8'h00)
    else $error("violation counter not cleared by read");

  a_occ_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    q.occ >= OCC_RESET && q.occ <= OCC_MAX)
    else $error("occurrence count out of range");

  a_min_drop_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    idle_gap_valid_i && !launch && idle_gap_pairs_i < q.min_pairs
    |=> q.idle_gap_event && q.occ == OCC_RESET && q.min_pairs == $past(idle_gap_pairs_i))
    else $error("idle gap minimum drop not recorded");

  a_link_limit_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    link_error_event_i && !launch && q.link_count + 8'h01 == q.link_error_limit |=> q.link_error_threshold_event)
    else $error("link error limit event missed");

  a_apb_answer: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch |=> pready_o ##1 !pready_o)
    else $error("APB answer not one cycle after access");

  a_rx_cleared: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    s_tx_write_idle |=> q.rx_signal_vector == 16'h0000)
    else $error("receive vector not cleared at start");

  a_idle_lines: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !q.sig_active |-> !tx_halt_o && !tx_master_o)
    else $error("line state driven while not signaling");

  a_viol_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    violation_symbol_i && !launch |=> q.viol_count == $past(q.viol_count) + 8'h01)
    else $error("violation counter did not step");

  a_viol_every: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    violation_symbol_i && !q.violation_event_select |=> q.violation_count_event)
    else $error("violation event missed");

  a_idle_read_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch && !pwrite_i && idx == IDX_IDLE_MONITOR && !idle_gap_valid_i
    |=> q.min_pairs == MIN_PAIRS_RESET && q.occ == OCC_RESET)
    else $error("idle gap monitor not cleared by read");

  a_occ_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    idle_gap_valid_i && !launch && idle_gap_pairs_i == q.min_pairs && q.occ != OCC_MAX
    |=> q.occ == $past(q.occ) + 5'h01)
    else $error("equal gap did not step occurrences");

  a_occ_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    idle_gap_valid_i && !launch && idle_gap_pairs_i == q.min_pairs && q.occ == OCC_MAX |=> q.occ == OCC_MAX)
    else $error("occurrence count left saturation");

  a_link_read_clear: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch && !pwrite_i && idx == IDX_LINK_COUNT && !link_error_event_i |=> q.link_count == 8'h00)
    else $error("link error counter not cleared by read");

  a_limit_write: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    acc && pwrite_i && idx == IDX_LINK_LIMIT |=> q.link_error_limit == $past(pwdata_i[7:0]))
    else $error("link error limit write lost");

  a_ro_write_resp: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    launch && pwrite_i && read_only |=> pslverr_o && pready_o)
    else $error("read-only write not answered with error");

  a_ro_write_flag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    acc && pwrite_i && read_only |=> q.host_access_error)
    else $error("read-only write did not flag host error");

endmodule : pbs_signal_counters
`default_nettype wire

// file: design/pbs_pkg.sv
package pbs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL_A = 6'h00;
  localparam logic [5:0] IDX_TX_VECTOR = 6'h03;
  localparam logic [5:0] IDX_VECTOR_COUNT = 6'h04;
  localparam logic [5:0] IDX_LINK_LIMIT = 6'h05;
  localparam logic [5:0] IDX_RX_VECTOR = 6'h16;
  localparam logic [5:0] IDX_EVENT_FLAGS = 6'h17;
  localparam logic [5:0] IDX_VIOL_COUNT = 6'h18;
  localparam logic [5:0] IDX_IDLE_MONITOR = 6'h19;
  localparam logic [5:0] IDX_LINK_COUNT = 6'h1a;
  // Field positions
  localparam int CTLA_VIOL_SEL_BIT = 0;
  localparam int CTLA_IDLE_SEL_BIT = 1;
  localparam int CTLA_SIG_ACTIVE_BIT = 2;
  localparam int EVT_HOST_ERR_BIT = 15;
  localparam int EVT_LINK_LIMIT_BIT = 13;
  localparam int EVT_IDLE_GAP_BIT = 12;
  localparam int EVT_VIOL_BIT = 11;
  // Values after reset and counter limits
  localparam logic [2:0] MIN_PAIRS_RESET = 3'h7;
  localparam logic [4:0] OCC_RESET = 5'h01;
  localparam logic [4:0] OCC_MAX = 5'h10;
  localparam logic [7:0] COUNT8_MAX = 8'hff;
  // Signaling interval per bit
  localparam int CLK_PERIOD_NS = 10;
  localparam int SIG_BIT_NS = 1000;
  localparam int SIG_BIT_CYCLES = (SIG_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic logic [2:0] min_pairs_code(input logic [2:0] pairs);
    case (pairs)
      3'h7: min_pairs_code = 3'h4;
      3'h6: min_pairs_code = 3'h5;
      3'h5: min_pairs_code = 3'h7;
      3'h4: min_pairs_code = 3'h6;
      3'h3: min_pairs_code = 3'h2;
      3'h2: min_pairs_code = 3'h3;
      3'h1: min_pairs_code = 3'h1;
      default: min_pairs_code = 3'h0;
    endcase
  endfunction : min_pairs_code

  function automatic logic [3:0] occ_code(input logic [4:0] occ);
    case (occ)
      5'h01: occ_code = 4'h0;
      5'h02: occ_code = 4'h8;
      5'h03: occ_code = 4'hc;
      5'h04: occ_code = 4'h4;
      5'h05: occ_code = 4'h5;
      5'h06: occ_code = 4'h7;
      5'h07: occ_code = 4'hf;
      5'h08: occ_code = 4'he;
      5'h09: occ_code = 4'ha;
      5'h0a: occ_code = 4'h2;
      5'h0b: occ_code = 4'h3;
      5'h0c: occ_code = 4'h1;
      5'h0d: occ_code = 4'h9;
      5'h0e: occ_code = 4'hd;
      5'h0f: occ_code = 4'h6;
      default: occ_code = 4'hb;
    endcase
  endfunction : occ_code
endpackage : pbs_pkg

// file: dv/pbs_neighbour_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbs_neighbour_model
  import pbs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Signaling state of the device
  input wire logic signaling_active_i,
  // Bits the neighbour answers with
  input wire logic [15:0] reply_i,
  // Line state back to the device
  output logic rx_halt_o
);
  int cnt_q;
  logic wander_q;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !signaling_active_i) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
    wander_q <= rstn_i ? ~wander_q : 1'b0;
  end
  // One answer bit per interval, bit 0 first; outside signaling the line wanders so stale samples show
  assign rx_halt_o = signaling_active_i ? reply_i[(cnt_q / SIG_BIT_CYCLES) % 16] : wander_q;
endmodule : pbs_neighbour_model
`default_nettype wire

// file: dv/test_pcm_bit_signal_and_link_counters.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_pcm_bit_signal_and_link_counters;
  import pbs_pkg::*;
  logic mclk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rd_err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_data;
  logic rx_halt_i, tx_halt_o, tx_master_o, signaling_active_o;
  logic violation_symbol_i, idle_gap_valid_i, link_error_event_i;
  logic [2:0] idle_gap_pairs_i;
  logic [15:0] reply_i;
  int n_errors, tests_run, cyc;

  pbs_signal_counters #(.ADDR_W(8)) DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_halt_i(rx_halt_i),
    .tx_halt_o(tx_halt_o), .tx_master_o(tx_master_o), .signaling_active_o(signaling_active_o),
    .violation_symbol_i(violation_symbol_i), .idle_gap_valid_i(idle_gap_valid_i),
    .idle_gap_pairs_i(idle_gap_pairs_i), .link_error_event_i(link_error_event_i));
  pbs_neighbour_model u_nbr (.mclk_i(mclk_i), .rstn_i(rstn_i), .signaling_active_i(signaling_active_o),
    .reply_i(reply_i), .rx_halt_o(rx_halt_i));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 1;

  task summarize;
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int k;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'h0};
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      summarize();
    end
    rd_data = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task wait_to(input int target);
    while (cyc < target) @(posedge mclk_i);
  endtask : wait_to

  // Kind 0 violation, 1 link error, else idle gap of the given pairs
  task pulse(input int kind, input int n, input logic [2:0] pairs);
    repeat (n) begin
      @(posedge mclk_i);
      case (kind)
        0: violation_symbol_i <= 1'b1;
        1: link_error_event_i <= 1'b1;
        default: begin
          idle_gap_valid_i <= 1'b1;
          idle_gap_pairs_i <= pairs;
        end
      endcase
      @(posedge mclk_i);
      {violation_symbol_i, link_error_event_i, idle_gap_valid_i} <= 3'h0;
    end
    @(posedge mclk_i);
  endtask : pulse

  task t_reset;
    logic [5:0] ids [8];
    ids = '{IDX_CONTROL_A, IDX_TX_VECTOR, IDX_VECTOR_COUNT, IDX_LINK_LIMIT, IDX_RX_VECTOR,
      IDX_EVENT_FLAGS, IDX_VIOL_COUNT, IDX_LINK_COUNT};
    foreach (ids[i]) begin
      xfer(1'b0, ids[i], 32'h0000_0000);
      `CHK(rd_data, 32'h0000_0000)
      `CHK(rd_err, 1'b0)
    end
    xfer(1'b0, 6'h3e, 32'h0000_0000);
    `CHK(rd_err, 1'b1)
    xfer(1'b0, IDX_IDLE_MONITOR, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0040)
  endtask : t_reset

  // Min detector must be seen before any read of the monitor clears it
  task t_idle;
    xfer(1'b1, IDX_CONTROL_A, 32'h0000_0000);
    pulse(2, 1, 3'h7);
    pulse(2, 1, 3'h3);
    pulse(2, 15, 3'h3);
    pulse(2, 1, 3'h5);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_1000)
    xfer(1'b0, IDX_IDLE_MONITOR, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_002b)
    xfer(1'b1, IDX_CONTROL_A, 32'h0000_0002);
    xfer(1'b0, IDX_CONTROL_A, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0002)
    pulse(2, 1, 3'h4);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_1000)
    pulse(2, 14, 3'h4);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0000)
    pulse(2, 1, 3'h4);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_1000)
    xfer(1'b0, IDX_IDLE_MONITOR, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_006b)
  endtask : t_idle

  task t_masks;
    xfer(1'b1, IDX_VECTOR_COUNT, 32'hffff_ffff);
    xfer(1'b0, IDX_VECTOR_COUNT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_000f)
    xfer(1'b1, IDX_LINK_LIMIT, 32'hffff_ffff);
    xfer(1'b0, IDX_LINK_LIMIT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_00ff)
    xfer(1'b1, IDX_RX_VECTOR, 32'h0000_1234);
    `CHK(rd_err, 1'b1)
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_8000)
  endtask : t_masks

  task t_signal;
    int t0;
    logic [2:0] bits;
    bits = 3'h5;
    reply_i <= 16'ha5a6;
    xfer(1'b1, IDX_VECTOR_COUNT, 32'h0000_0002);
    xfer(1'b1, IDX_TX_VECTOR, 32'h0000_0005);
    t0 = cyc;
    for (int n = 0; n < 3; n++) begin
      wait_to(t0 + n * SIG_BIT_CYCLES + SIG_BIT_CYCLES / 2);
      `CHK(tx_halt_o, bits[n])
      `CHK(tx_master_o, ~bits[n])
      `CHK(signaling_active_o, 1'b1)
      if (n == 0) begin
        xfer(1'b1, IDX_TX_VECTOR, 32'h0000_ffff);
        `CHK(rd_err, 1'b0)
        xfer(1'b1, IDX_VECTOR_COUNT, 32'h0000_000f);
        xfer(1'b0, IDX_TX_VECTOR, 32'h0000_0000);
        `CHK(rd_data, 32'h0000_0005)
        xfer(1'b0, IDX_VECTOR_COUNT, 32'h0000_0000);
        `CHK(rd_data, 32'h0000_0002)
        xfer(1'b0, IDX_CONTROL_A, 32'h0000_0000);
        `CHK(rd_data, 32'h0000_0006)
      end
    end
    wait_to(t0 + 3 * SIG_BIT_CYCLES + 5);
    `CHK({signaling_active_o, tx_halt_o, tx_master_o}, 3'h0)
    xfer(1'b0, IDX_RX_VECTOR, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0006)
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_8000)
  endtask : t_signal

  task t_viol;
    xfer(1'b1, IDX_CONTROL_A, 32'h0000_0000);
    pulse(0, 3, 3'h0);
    xfer(1'b0, IDX_VIOL_COUNT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0003)
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0800)
    xfer(1'b0, IDX_VIOL_COUNT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0000)
    xfer(1'b1, IDX_CONTROL_A, 32'h0000_0001);
    pulse(0, 255, 3'h0);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0000)
    pulse(0, 1, 3'h0);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0800)
    xfer(1'b0, IDX_VIOL_COUNT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0000)
  endtask : t_viol

  task t_link;
    xfer(1'b1, IDX_LINK_LIMIT, 32'h0000_0003);
    pulse(1, 2, 3'h0);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0000)
    pulse(1, 1, 3'h0);
    xfer(1'b0, IDX_EVENT_FLAGS, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_2000)
    xfer(1'b0, IDX_LINK_COUNT, 32'h0000_0000);
    `CHK(rd_data, 32'h0000_0003)
  endtask : t_link

  initial begin
    {rstn_i, psel_i, penable_i, pwrite_i, violation_symbol_i, idle_gap_valid_i, link_error_event_i} = 7'h00;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    idle_gap_pairs_i = 3'h0;
    reply_i = 16'h0000;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_idle();
    t_masks();
    t_signal();
    t_viol();
    t_link();
    // Second reset with live values in the control, vector and limit registers
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset();
    summarize();
  end
endmodule : test_pcm_bit_signal_and_link_counters
`default_nettype wire
